// ---- logic/wcp_top.sv ----
// Functional notes
// - The always-on fuse picks the safety level: unprogrammed is level 1, programmed level 2.
// - In level 1 the watchdog starts disabled and any write of enable one with byte strobe 0 set turns it on.
// - In level 1 clearing enable or changing the time-out needs an open change window.
// - In level 1 a write with change-enable zero inside the window applies enable and time-out.
// - In level 2 the watchdog always runs and enable always reads as one.
// - In level 2 a write with change-enable zero inside the window applies only the time-out.
// - Change-enable, written to one together with enable one, clears itself four core cycles later.
// - The time-out select picks 16384 to 2097152 oscillator cycles, doubling per step.
// - The counter clears on a kick, while disabled, and on chip reset.
// - Expiry without a kick gives a reset pulse one core cycle long.
`timescale 1ns/1ps
module wcp_top #(
    parameter int PERIOD_BASE = wcp_pkg::PERIOD_BASE
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        always_on_fuse,
    input  wire logic        kick_instruction,
    input  wire logic        osc_tick,
    output logic             wdt_reset_pulse,
    input  wire logic [3:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [3:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    wcp_pkg::wcp_ctrl_t ctrl_q;
    logic [2:0]         win_cnt_q;
    logic               level2_q;
    logic               fuse_taken_q;
    logic               aw_have_q;
    logic               w_have_q;
    logic [3:0]         aw_addr_q;
    logic [31:0]        w_data_q;
    logic [3:0]         w_strb_q;

    logic               wr_fire;
    logic               wr_ctrl;
    logic               wr_en_bit;
    logic               wr_ce_bit;
    logic [2:0]         wr_tsel;
    logic               win_open;
    logic               run;
    logic [31:0]        ctrl_rd;
    logic [31:0]        status_rd;

    // ----------------------------------------------------------------
    // fuse capture
    // ----------------------------------------------------------------
    // the fuse is caught once after reset release, so a glitch later cannot
    // drop the watchdog back to the software controlled level
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            level2_q     <= 1'b0;
            fuse_taken_q <= 1'b0;
        end else if (!fuse_taken_q) begin
            level2_q     <= always_on_fuse;
            fuse_taken_q <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // decode of a committed write
    // ----------------------------------------------------------------
    always_comb begin
        wr_fire   = aw_have_q && w_have_q && !s_axi_bvalid;
        wr_ctrl   = wr_fire && (aw_addr_q == wcp_pkg::CTRL_OFFSET) && w_strb_q[0];
        wr_en_bit = w_data_q[wcp_pkg::ENABLE_BIT];
        wr_ce_bit = w_data_q[wcp_pkg::CHANGE_BIT];
        wr_tsel   = w_data_q[wcp_pkg::TSEL_MSB:wcp_pkg::TSEL_LSB];
        win_open  = (win_cnt_q != 3'h0);
        run       = ctrl_q.en || level2_q;
    end

    // ----------------------------------------------------------------
    // change window
    // ----------------------------------------------------------------
    // a second opening write restarts the window; an applying write closes it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            win_cnt_q <= 3'h0;
        end else if (wr_ctrl && wr_ce_bit && wr_en_bit) begin
            win_cnt_q <= wcp_pkg::CHANGE_WINDOW;
        end else if (wr_ctrl && win_open) begin
            win_cnt_q <= 3'h0;
        end else if (win_open) begin
            win_cnt_q <= win_cnt_q - 3'h1;
        end
    end

    // ----------------------------------------------------------------
    // protected settings
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q.en   <= wcp_pkg::ENABLE_RESET;
            ctrl_q.tsel <= wcp_pkg::TSEL_RESET;
        end else if (wr_ctrl && win_open && !wr_ce_bit) begin
            ctrl_q.tsel <= wr_tsel;
            if (!level2_q) begin
                ctrl_q.en <= wr_en_bit;
            end
        end else if (wr_ctrl && wr_en_bit) begin
            ctrl_q.en <= 1'b1;
        end
        // any other write, or a window left to lapse, keeps both fields
    end

    // ----------------------------------------------------------------
    // timeout counter
    // ----------------------------------------------------------------
    wcp_timer #(
        .PERIOD_BASE (PERIOD_BASE)
    ) u_timer (
        .clk      (clk),
        .rst_n    (rst_n),
        .run      (run),
        .kick     (kick_instruction),
        .osc_tick (osc_tick),
        .tsel     (ctrl_q.tsel),
        .expire_q (wdt_reset_pulse)
    );

    // ----------------------------------------------------------------
    // axi4-lite write channels
    // ----------------------------------------------------------------
    // address and data are caught in either order; ready drops until the
    // response has been taken, so one write at most is in flight
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            aw_have_q     <= 1'b0;
            aw_addr_q     <= 4'h0;
            s_axi_awready <= 1'b0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_have_q     <= 1'b1;
            aw_addr_q     <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
        end else begin
            if (wr_fire) begin
                aw_have_q <= 1'b0;
            end
            s_axi_awready <= !aw_have_q && !s_axi_bvalid;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            w_have_q     <= 1'b0;
            w_data_q     <= 32'h0;
            w_strb_q     <= 4'h0;
            s_axi_wready <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_have_q     <= 1'b1;
            w_data_q     <= s_axi_wdata;
            w_strb_q     <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
        end else begin
            if (wr_fire) begin
                w_have_q <= 1'b0;
            end
            s_axi_wready <= !w_have_q && !s_axi_bvalid;
        end
    end

    // write response; the status word is read only, so a write to it errors
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= wcp_pkg::RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (aw_addr_q == wcp_pkg::CTRL_OFFSET) ? wcp_pkg::RESP_OKAY
                                                                : wcp_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // axi4-lite read channels
    // ----------------------------------------------------------------
    always_comb begin
        ctrl_rd                                            = 32'h0;
        ctrl_rd[wcp_pkg::TSEL_MSB:wcp_pkg::TSEL_LSB]       = ctrl_q.tsel;
        ctrl_rd[wcp_pkg::ENABLE_BIT]                       = run;
        ctrl_rd[wcp_pkg::CHANGE_BIT]                       = win_open;
        status_rd                                          = 32'h0;
        status_rd[wcp_pkg::LEVEL2_BIT]                     = level2_q;
        status_rd[wcp_pkg::RUNNING_BIT]                    = run;
    end

    // reads answer one cycle after the address is taken
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0;
            s_axi_rresp   <= wcp_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            if (s_axi_araddr == wcp_pkg::CTRL_OFFSET) begin
                s_axi_rdata <= ctrl_rd;
                s_axi_rresp <= wcp_pkg::RESP_OKAY;
            end else if (s_axi_araddr == wcp_pkg::STATUS_OFFSET) begin
                s_axi_rdata <= status_rd;
                s_axi_rresp <= wcp_pkg::RESP_OKAY;
            end else begin
                s_axi_rdata <= 32'h0;
                s_axi_rresp <= wcp_pkg::RESP_SLVERR;
            end
        end else if (s_axi_rvalid) begin
            if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end else begin
            s_axi_arready <= 1'b1;
        end
    end

endmodule : wcp_top

// ---- logic/wcp_pkg.sv ----
package wcp_pkg;

    // ----------------------------------------------------------------
    // register map, byte addresses on the AXI4-Lite port
    // ----------------------------------------------------------------
    localparam logic [3:0] CTRL_OFFSET   = 4'h0;
    localparam logic [3:0] STATUS_OFFSET = 4'h4;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int TSEL_LSB     = 0;
    localparam int TSEL_MSB     = 2;
    localparam int ENABLE_BIT   = 3;
    localparam int CHANGE_BIT   = 4;
    localparam int LEVEL2_BIT   = 0;
    localparam int RUNNING_BIT  = 1;

    // ----------------------------------------------------------------
    // reset values and timing
    // ----------------------------------------------------------------
    localparam logic       ENABLE_RESET  = 1'b0;
    localparam logic [2:0] TSEL_RESET    = 3'h0;
    localparam logic [2:0] CHANGE_WINDOW = 3'h4;   // core cycles the change window stays open
    localparam int         PERIOD_BASE   = 16384;  // oscillator cycles for select code 000
    localparam int         PERIOD_W      = 22;     // holds the longest period, code 111

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ----------------------------------------------------------------
    // carrier for the protected settings
    // ----------------------------------------------------------------
    typedef struct packed {
        logic       en;
        logic [2:0] tsel;
    } wcp_ctrl_t;

endpackage : wcp_pkg

// ---- logic/wcp_timer.sv ----
`timescale 1ns/1ps
module wcp_timer #(
    parameter int PERIOD_BASE = wcp_pkg::PERIOD_BASE
) (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       run,
    input  wire logic       kick,
    input  wire logic       osc_tick,
    input  wire logic [2:0] tsel,
    output logic            expire_q
);

    logic [wcp_pkg::PERIOD_W-1:0] cnt_q;
    logic [wcp_pkg::PERIOD_W-1:0] limit;
    logic [31:0]                  limit_wide;

    // ----------------------------------------------------------------
    // period select, doubling per code step
    // ----------------------------------------------------------------
    always_comb begin
        limit_wide = 32'(PERIOD_BASE) << tsel;
        limit      = limit_wide[wcp_pkg::PERIOD_W-1:0] - 22'h1;
    end

    // counter clears on kick and while stopped; only chip reset is async
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= '0;
        end else if (!run || kick) begin
            cnt_q <= '0;
        end else if (osc_tick) begin
            cnt_q <= (cnt_q >= limit) ? '0 : cnt_q + 22'h1;
        end
    end

    // one core cycle pulse when the period runs out without a kick
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            expire_q <= 1'b0;
        end else begin
            expire_q <= run && !kick && osc_tick && (cnt_q >= limit);
        end
    end

endmodule : wcp_timer

// ---- tb/wcp_properties.sv ----
`timescale 1ns/1ps
module wcp_properties #(
    parameter int PERIOD_BASE = wcp_pkg::PERIOD_BASE
) (
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        always_on_fuse,
    input wire logic        kick_instruction,
    input wire logic        osc_tick,
    input wire logic        wdt_reset_pulse,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [3:0]  s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid
);
    logic [3:0] rd_addr_q;

    // ----------------------------------------------------------------
    // read address tracking
    // ----------------------------------------------------------------
    // rdata carries no address, so remember which register it answers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_addr_q <= 4'h0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rd_addr_q <= s_axi_araddr;
        end
    end

    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_wr_answer;
        !s_axi_awready && !s_axi_bvalid ##1 s_axi_bvalid;
    endsequence

    a_write_answer: assert property (s_wr_take |=> s_wr_answer)
        else $error("write response late or early");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("read data not returned next cycle");
    a_ready_return: assert property (s_axi_bvalid && s_axi_bready |=>
        !s_axi_bvalid ##1 (s_axi_awready && s_axi_wready))
        else $error("write channel not reopened after response");
    a_pulse_single: assert property (wdt_reset_pulse |=> !wdt_reset_pulse)
        else $error("reset pulse longer than one cycle");
    a_pulse_tick: assert property (wdt_reset_pulse |-> $past(osc_tick))
        else $error("reset pulse without a preceding tick");
    a_kick_quiet: assert property (kick_instruction |=> !wdt_reset_pulse [*4])
        else $error("reset pulse too soon after kick");
    a_level2_enable: assert property (s_axi_rvalid && always_on_fuse &&
        rd_addr_q == wcp_pkg::CTRL_OFFSET |-> s_axi_rdata[wcp_pkg::ENABLE_BIT])
        else $error("enable reads zero at level 2");
    a_level_status: assert property (s_axi_rvalid && rd_addr_q == wcp_pkg::STATUS_OFFSET
        |-> s_axi_rdata[wcp_pkg::LEVEL2_BIT] == always_on_fuse)
        else $error("status level differs from fuse");
endmodule : wcp_properties

bind wcp_top wcp_properties #(.PERIOD_BASE(PERIOD_BASE)) u_props (
    .clk(clk), .rst_n(rst_n), .always_on_fuse(always_on_fuse),
    .kick_instruction(kick_instruction), .osc_tick(osc_tick),
    .wdt_reset_pulse(wdt_reset_pulse), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid));

// ---- tb/test_watchdog_change_protection.sv ----
`timescale 1ns/1ps
module test_watchdog_change_protection;
    localparam logic [3:0] CT = wcp_pkg::CTRL_OFFSET;
    localparam logic [3:0] ST = wcp_pkg::STATUS_OFFSET;
    localparam logic [1:0] OK = wcp_pkg::RESP_OKAY;
    localparam logic [1:0] SE = wcp_pkg::RESP_SLVERR;
    localparam int         PB = 4;  // short base period keeps the run brief

    // ----------------------------------------------------------------
    // stimulus and observed signals
    // ----------------------------------------------------------------
    logic        clk = 1'b0, rst_n = 1'b0, always_on_fuse = 1'b0;
    logic        kick_instruction = 1'b0, osc_tick = 1'b0, wdt_reset_pulse;
    logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, r;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
    logic        s_axi_bready = 1'b1, s_axi_rready = 1'b1;  // responses always accepted
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    integer      seed, err_count = 0, comparisons = 0;

    always #10 clk = ~clk;

    wcp_top #(.PERIOD_BASE(PB)) uut (.clk, .rst_n, .always_on_fuse, .kick_instruction,
        .osc_tick, .wdt_reset_pulse, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

    // ----------------------------------------------------------------
    // expectations and checking
    // ----------------------------------------------------------------
    function automatic logic [31:0] ctrl_word(input logic en, input logic [2:0] t);
        return {28'h0, en, t};
    endfunction : ctrl_word

    // oscillator ticks to expiry, doubling per select step
    function automatic logic [31:0] period(input logic [2:0] t);
        return 32'(PB) << t;
    endfunction : period

    task automatic end_sim;
        $display("comparisons %0d errors %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("Error t=%0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // one bounded wait step; running out counts a mismatch and ends the run
    task automatic guard(inout int n);
        n++;
        if (n > 50) begin
            err_count++;
            end_sim();
        end
    endtask : guard

    // ----------------------------------------------------------------
    // bus tasks: ready/valid looked at on falling edges, where settled
    // ----------------------------------------------------------------
    // address and data offered together, each released at its own handshake
    task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s,
                      input logic [1:0] er);
        int   n;
        logic aw_t, w_t, aw_done, w_done;
        n = 0;
        aw_done = 1'b0;
        w_done = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        while (!(aw_done && w_done)) begin
            @(negedge clk);
            guard(n);
            aw_t = !aw_done && s_axi_awready;
            w_t = !w_done && s_axi_wready;
            @(posedge clk);
            if (aw_t) begin
                s_axi_awvalid <= 1'b0;
                aw_done = 1'b1;
            end
            if (w_t) begin
                s_axi_wvalid <= 1'b0;
                w_done = 1'b1;
            end
        end
        @(negedge clk);
        while (!s_axi_bvalid) begin
            guard(n);
            @(negedge clk);
        end
        chk({30'h0, s_axi_bresp}, {30'h0, er});
        @(posedge clk);
    endtask : wr

    task automatic rd(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
        int n;
        n = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        @(negedge clk);
        while (!s_axi_arready) begin
            guard(n);
            @(negedge clk);
        end
        @(posedge clk);
        s_axi_arvalid <= 1'b0;
        @(negedge clk);
        while (!s_axi_rvalid) begin
            guard(n);
            @(negedge clk);
        end
        chk(s_axi_rdata, ed);
        chk({30'h0, s_axi_rresp}, {30'h0, er});
        @(posedge clk);
    endtask : rd

    // kick, then feed random ticks; stop at the pulse, or one tick past the
    // period so a stopped watchdog is given every chance to fire wrongly
    task automatic timer(input logic [2:0] t, input logic on);
        int   n, c;
        logic hit;
        n = 0;
        hit = 1'b0;
        kick_instruction <= 1'b1;
        osc_tick <= 1'b0;
        @(posedge clk);
        kick_instruction <= 1'b0;
        for (c = 0; c < 3000 && !hit && 32'(n) <= period(t); c++) begin
            r = $random(seed);
            osc_tick <= r[0];
            @(negedge clk);
            hit = wdt_reset_pulse;
            if (osc_tick && !hit) n++;
            @(posedge clk);
        end
        osc_tick <= 1'b0;
        chk({31'h0, hit}, {31'h0, on});
        chk(32'(n), on ? period(t) : period(t) + 32'h1);
    endtask : timer

    task automatic do_reset(input logic f);
        rst_n <= 1'b0;
        always_on_fuse <= f;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
    endtask : do_reset

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        seed = 32'h549cd640;
        do_reset(1'b0);
        rd(CT, 32'h0, OK);
        rd(ST, 32'h0, OK);
        rd(4'h8, 32'h0, SE);
        wr(ST, 32'h1, 4'hf, SE);
        wr(CT, 32'h0b, 4'hf, OK);
        rd(CT, 32'h08, OK);
        wr(CT, 32'h00, 4'hf, OK);
        wr(CT, 32'h18, 4'he, OK);
        wr(CT, 32'h03, 4'hf, OK);
        rd(CT, 32'h08, OK);
        for (int t = 0; t < 8; t++) begin
            r = $random(seed);
            wr(CT, 32'h18, 4'hf, OK);
            wr(CT, ctrl_word(r[0], 3'(t)), 4'hf, OK);
            rd(CT, ctrl_word(r[0], 3'(t)), OK);
            timer(3'(t), r[0]);
        end
        // the read shows the open window and delays the next commit one cycle past it
        wr(CT, 32'h18, 4'hf, OK);
        rd(CT, 32'h1f, OK);
        wr(CT, 32'h02, 4'hf, OK);
        rd(CT, ctrl_word(1'b1, 3'h7), OK);
        wr(CT, 32'h18, 4'hf, OK);
        wr(CT, 32'h02, 4'hf, OK);
        rd(ST, 32'h0, OK);
        timer(3'h2, 1'b0);
        do_reset(1'b1);
        rd(CT, 32'h08, OK);
        rd(ST, 32'h3, OK);
        wr(CT, 32'h00, 4'hf, OK);
        rd(CT, 32'h08, OK);
        wr(CT, 32'h18, 4'hf, OK);
        wr(CT, 32'h05, 4'hf, OK);
        rd(CT, 32'h0d, OK);
        timer(3'h5, 1'b1);
        end_sim();
    end
endmodule : test_watchdog_change_protection
